// [card_host_readwait_taskfile.sv]
// Card host command engine with read-wait stall and task-file data phase
`timescale 1ns/10ps
`include "card_host_regs.svh"
module card_host_readwait_taskfile import card_host_pkg::*; (
  // Clock and control
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        ce,
  // Register port
  input  wire logic [8:0]  regAddr,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  input  wire logic [31:0] regWrData,
  output logic      [31:0] regRdData,
  // Card bus
  output logic             cardClk,
  output logic             cmdOut,
  output logic             cmdOe,
  input  wire logic        cmdIn,
  output logic             dat0Out,
  output logic             dat0Oe,
  input  wire logic        dat0In,
  output logic             dat2Out,
  output logic             dat2Oe
);

  // ================================================================
  // Declarations
  logic [31:0] ctrl_ff, tmout_ff, blkSize_ff, byteCnt_ff, command_argument_ff, resp_ff, rdData_ff;
  cmd_t        cmd_ff, curCmd_ff;
  sticky_t     stat_ff;
  logic        resumeFlag_ff;
  cmd_state_t  cState_ff;
  dat_state_t  dState_ff;
  logic        cmdMeta_ff, cmdSync_ff, datMeta_ff, datSync_ff;
  logic [7:0]  divCnt_ff, bitCnt_ff, waitCnt_ff;
  logic        cardClk_ff, cmdOut_ff, cmdOe_ff, dat0Out_ff, dat0Oe_ff, dat2Out_ff, dat2Oe_ff;
  logic [47:0] cmdSh_ff;
  logic [9:0]  dBits_ff, dCnt_ff;
  logic [31:0] toCnt_ff, rxSh_ff, txSh_ff;
  logic [3:0]  engPtr_ff, swPtr_ff;
  logic [31:0] memRdata;
  logic [47:0] respWord;
  logic [4:0]  stSet, stClr;

  // CRC7 over a 40-bit command or response head
  function automatic logic [6:0] crc7Of(input logic [39:0] bits);
    logic [6:0] crc;
    logic       fb;
    crc = 7'h00;
    fb  = 1'b0;
    for (int i = 39; i >= 0; i--) begin
      fb  = bits[i] ^ crc[6];
      crc = {crc[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
    end
    return crc;
  endfunction

  // Data phase length in bits, clipped to the buffer
  function automatic logic [9:0] xferBits(input cmd_t c, input logic [31:0] blk,
                                          input logic [31:0] cnt);
    logic [31:0] n;
    n = (c.index == `TASKFILE_CMD) ? blk : cnt;
    if (n > `BUF_BYTES) begin
      n = `BUF_BYTES;
    end
    return {n[6:0], 3'b000};
  endfunction

  // ================================================================
  // Bus decode
  wire wrCtrl  = regWrEn && (regAddr == `OFS_CTRL);
  wire wrTmout = regWrEn && (regAddr == `OFS_TMOUT);
  wire wrBlk   = regWrEn && (regAddr == `OFS_BLKSZ);
  wire wrBytes = regWrEn && (regAddr == `OFS_BYTES);
  wire wrArg   = regWrEn && (regAddr == `OFS_CARG);
  wire wrCmd   = regWrEn && (regAddr == `OFS_CMD);
  wire wrStat  = regWrEn && (regAddr == `OFS_STAT);
  wire wrData  = regWrEn && (regAddr == `OFS_DATA);
  wire rdData  = regRdEn && (regAddr == `OFS_DATA);
  wire abortPulse = wrCtrl && regWrData[`CTRL_ABORT_BIT];

  // ================================================================
  // Engine conditions
  wire dataBusy = (dState_ff != D_IDLE);
  wire cmdBusy  = cmd_ff.start || (cState_ff != C_IDLE);
  wire divHit   = (divCnt_ff == `CARD_HALF_M1);
  wire riseTick = divHit && !cardClk_ff;
  wire fallTick = divHit && cardClk_ff;
  wire accept   = (cState_ff == C_IDLE) && cmd_ff.start && !(cmd_ff.waitPrv && dataBusy);
  wire sendEnd  = (cState_ff == C_SEND) && fallTick && (bitCnt_ff == `CMD_FRAME_BITS);
  wire respLast = (bitCnt_ff == (curCmd_ff.respLong ? `RESP_LONG_LAST : `RESP_SHORT_LAST));
  wire respDone = (cState_ff == C_RESP) && riseTick && respLast;
  wire respTo   = (cState_ff == C_RWAIT) && riseTick && cmdSync_ff && (waitCnt_ff == `RESP_WAIT);
  assign respWord = {cmdSh_ff[46:0], cmdSync_ff};
  wire crcBad   = !curCmd_ff.respLong && (crc7Of(respWord[47:8]) != respWord[7:1]);
  wire crcFail  = curCmd_ff.checkCrc && crcBad;
  wire cmdFinish = sendEnd && !curCmd_ff.respExp || respDone || respTo || accept && cmd_ff.updClk;
  wire dataGo   = curCmd_ff.dataExp && (sendEnd && !curCmd_ff.respExp || respDone && !crcFail);
  wire [9:0] nxtBits = xferBits(curCmd_ff, blkSize_ff, byteCnt_ff);
  wire rdTimeout = (dState_ff == D_RSTART) && riseTick && datSync_ff && (toCnt_ff == tmout_ff);
  wire rdEnd    = (dState_ff == D_RBITS) && riseTick && (dCnt_ff == dBits_ff - 10'h001);
  wire wrEnd    = (dState_ff == D_WSEND) && fallTick && (dCnt_ff == dBits_ff + 10'h002);
  wire engWe    = (dState_ff == D_RBITS) && riseTick && ((dCnt_ff[4:0] == 5'h1F) || rdEnd);

  // ================================================================
  // Pin synchronisers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cmdMeta_ff <= 1'b1;
      cmdSync_ff <= 1'b1;
      datMeta_ff <= 1'b1;
      datSync_ff <= 1'b1;
    end else if (ce) begin
      cmdMeta_ff <= cmdIn;
      cmdSync_ff <= cmdMeta_ff;
      datMeta_ff <= dat0In;
      datSync_ff <= datMeta_ff;
    end
  end

  // Card clock divider
  always_ff @(posedge core_clk) begin
    if (srst) begin
      divCnt_ff  <= 8'h00;
      cardClk_ff <= 1'b0;
    end else if (ce) begin
      divCnt_ff <= divHit ? 8'h00 : divCnt_ff + 8'h01;
      if (divHit) begin
        cardClk_ff <= !cardClk_ff;
      end
    end
  end

  // ================================================================
  // Software registers; abort bit is a pulse and never stored
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_ff    <= `RST_CTRL;
      tmout_ff   <= `RST_TMOUT;
      blkSize_ff <= `RST_BLKSZ;
      byteCnt_ff <= `RST_BYTES;
      command_argument_ff  <= `RST_CARG;
    end else if (ce) begin
      if (wrCtrl) ctrl_ff <= regWrData & ~(32'h0000_0001 << `CTRL_ABORT_BIT);
      if (wrTmout) tmout_ff <= regWrData;
      if (wrBlk) blkSize_ff <= regWrData;
      if (wrBytes) byteCnt_ff <= regWrData;
      if (wrArg) command_argument_ff <= regWrData;
    end
  end

  // Command register; a write while launch is pending is ignored
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cmd_ff <= cmd_t'(`RST_CMD);
    end else if (ce) begin
      if (wrCmd && !cmd_ff.start) begin
        cmd_ff <= cmd_t'(regWrData);
      end else if (accept) begin
        cmd_ff.start <= 1'b0;
      end
    end
  end

  // Sticky flags: write one to clear, a new event wins over the clear
  always_comb begin
    stSet                 = 5'h00;
    stSet[`ST_CMD_DONE]   = cmdFinish;
    stSet[`ST_RESP_TO]    = respTo;
    stSet[`ST_RESP_CRC]   = respDone && crcFail;
    stSet[`ST_DATA_DONE]  = rdEnd || wrEnd;
    stSet[`ST_DATA_TO]    = rdTimeout;
    stClr                 = wrStat ? regWrData[4:0] : 5'h00;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      stat_ff <= sticky_t'(5'h00);
    end else if (ce) begin
      stat_ff <= sticky_t'((stat_ff & ~stClr) | stSet);
    end
  end

  // Response word and resume data flag
  always_ff @(posedge core_clk) begin
    if (srst) begin
      resp_ff       <= 32'h0000_0000;
      resumeFlag_ff <= 1'b0;
    end else if (ce && respDone) begin
      resp_ff       <= respWord[39:8];
      resumeFlag_ff <= respWord[`RESP_RESUME_BIT];
    end
  end

  // Register read, answered one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdData_ff <= 32'h0000_0000;
    end else if (ce && regRdEn) begin
      unique case (regAddr)
        `OFS_CTRL:  rdData_ff <= ctrl_ff;
        `OFS_TMOUT: rdData_ff <= tmout_ff;
        `OFS_BLKSZ: rdData_ff <= blkSize_ff;
        `OFS_BYTES: rdData_ff <= byteCnt_ff;
        `OFS_CARG:  rdData_ff <= command_argument_ff;
        `OFS_CMD:   rdData_ff <= cmd_ff;
        `OFS_RESP:  rdData_ff <= resp_ff;
        `OFS_STAT:  rdData_ff <= {21'h00_0000, resumeFlag_ff, dataBusy, cmdBusy, 3'h0, stat_ff};
        `OFS_DATA:  rdData_ff <= memRdata;
        default:    rdData_ff <= 32'h0000_0000;
      endcase
    end
  end

  // Software buffer pointer, rewound at each launch
  always_ff @(posedge core_clk) begin
    if (srst) begin
      swPtr_ff <= 4'h0;
    end else if (ce) begin
      if (accept) swPtr_ff <= 4'h0;
      else if ((wrData || rdData) && !dataBusy) swPtr_ff <= swPtr_ff + 4'h1;
    end
  end

  // ================================================================
  // Read-wait stall on data line 2, held for as long as software asks
  always_ff @(posedge core_clk) begin
    if (srst) begin
      dat2Out_ff <= 1'b0;
      dat2Oe_ff  <= 1'b0;
    end else if (ce) begin
      dat2Out_ff <= 1'b0;
      dat2Oe_ff  <= ctrl_ff[`CTRL_STALL_BIT];
    end
  end

  // ================================================================
  // Command engine; card select field is ignored, one card only
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cState_ff  <= C_IDLE;
      curCmd_ff  <= cmd_t'(`RST_CMD);
      cmdSh_ff   <= 48'h0000_0000_0000;
      bitCnt_ff  <= 8'h00;
      waitCnt_ff <= 8'h00;
      cmdOut_ff  <= 1'b1;
      cmdOe_ff   <= 1'b0;
    end else if (ce) begin
      unique case (cState_ff)
        C_IDLE: if (accept) begin
          curCmd_ff <= cmd_ff;
          cmdSh_ff  <= {2'b01, cmd_ff.index, command_argument_ff,
                        crc7Of({2'b01, cmd_ff.index, command_argument_ff}), 1'b1};
          bitCnt_ff <= 8'h00;
          cState_ff <= cmd_ff.updClk ? C_IDLE : C_SEND;
        end
        C_SEND: if (fallTick) begin
          if (sendEnd) begin
            cmdOe_ff   <= 1'b0;
            cmdOut_ff  <= 1'b1;
            bitCnt_ff  <= 8'h00;
            waitCnt_ff <= 8'h00;
            cState_ff  <= curCmd_ff.respExp ? C_RWAIT : C_IDLE;
          end else begin
            cmdOe_ff  <= 1'b1;
            cmdOut_ff <= cmdSh_ff[47];
            cmdSh_ff  <= {cmdSh_ff[46:0], 1'b1};
            bitCnt_ff <= bitCnt_ff + 8'h01;
          end
        end
        C_RWAIT: if (riseTick) begin
          if (!cmdSync_ff) begin
            cmdSh_ff  <= 48'h0000_0000_0000;
            bitCnt_ff <= 8'h01;
            cState_ff <= C_RESP;
          end else if (respTo) begin
            cState_ff <= C_IDLE;
          end else begin
            waitCnt_ff <= waitCnt_ff + 8'h01;
          end
        end
        C_RESP: if (riseTick) begin
          // No completion signal is awaited after the response
          cmdSh_ff  <= respWord;
          bitCnt_ff <= bitCnt_ff + 8'h01;
          if (respDone) cState_ff <= C_IDLE;
        end
      endcase
    end
  end

  // ================================================================
  // Data engine on data line 0, one block for a task-file command
  always_ff @(posedge core_clk) begin
    if (srst) begin
      dState_ff  <= D_IDLE;
      dBits_ff   <= 10'h000;
      dCnt_ff    <= 10'h000;
      toCnt_ff   <= 32'h0000_0000;
      rxSh_ff    <= 32'h0000_0000;
      txSh_ff    <= 32'h0000_0000;
      engPtr_ff  <= 4'h0;
      dat0Out_ff <= 1'b1;
      dat0Oe_ff  <= 1'b0;
    end else if (ce) begin
      if (abortPulse) begin
        dState_ff  <= D_IDLE;
        dat0Out_ff <= 1'b1;
        dat0Oe_ff  <= 1'b0;
      end else begin
        unique case (dState_ff)
          D_IDLE: if (dataGo && (nxtBits != 10'h000)) begin
            dBits_ff  <= nxtBits;
            dCnt_ff   <= 10'h000;
            toCnt_ff  <= 32'h0000_0000;
            engPtr_ff <= 4'h0;
            dState_ff <= curCmd_ff.readWrite ? D_WSEND : D_RSTART;
          end
          // Without pending card data the wait runs into the timeout
          D_RSTART: if (riseTick) begin
            if (!datSync_ff) dState_ff <= D_RBITS;
            else if (rdTimeout) dState_ff <= D_IDLE;
            else toCnt_ff <= toCnt_ff + 32'h0000_0001;
          end
          D_RBITS: if (riseTick) begin
            rxSh_ff <= {rxSh_ff[30:0], datSync_ff};
            dCnt_ff <= dCnt_ff + 10'h001;
            if (engWe) engPtr_ff <= engPtr_ff + 4'h1;
            if (rdEnd) dState_ff <= D_IDLE;
          end
          D_WSEND: if (fallTick) begin
            if (wrEnd) begin
              dat0Oe_ff  <= 1'b0;
              dat0Out_ff <= 1'b1;
              dState_ff  <= D_IDLE;
            end else begin
              dat0Oe_ff <= 1'b1;
              dCnt_ff   <= dCnt_ff + 10'h001;
              if (dCnt_ff == 10'h000) begin
                dat0Out_ff <= 1'b0;
                txSh_ff    <= memRdata;
                engPtr_ff  <= engPtr_ff + 4'h1;
              end else if (dCnt_ff == dBits_ff + 10'h001) begin
                dat0Out_ff <= 1'b1;
              end else begin
                dat0Out_ff <= txSh_ff[31];
                if (dCnt_ff[4:0] == 5'h00) begin
                  txSh_ff   <= memRdata;
                  engPtr_ff <= engPtr_ff + 4'h1;
                end else begin
                  txSh_ff <= {txSh_ff[30:0], 1'b0};
                end
              end
            end
          end
        endcase
      end
    end
  end

  // ================================================================
  // Data buffer shared by software and the data engine
  card_buf_mem u_buf (
    .core_clk (core_clk),
    .srst     (srst),
    .ce       (ce),
    .wrEn     (engWe || (wrData && !dataBusy)),
    .addr     (dataBusy ? engPtr_ff : swPtr_ff),
    .wrData   (engWe ? {rxSh_ff[30:0], datSync_ff} : regWrData),
    .rdData   (memRdata)
  );

  // Outputs
  assign regRdData = rdData_ff;
  assign cardClk   = cardClk_ff;
  assign cmdOut    = cmdOut_ff;
  assign cmdOe     = cmdOe_ff;
  assign dat0Out   = dat0Out_ff;
  assign dat0Oe    = dat0Oe_ff;
  assign dat2Out   = dat2Out_ff;
  assign dat2Oe    = dat2Oe_ff;

  // ================================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // Short names used by the checks
  wire stallReq = ctrl_ff[`CTRL_STALL_BIT];
  wire cIdle    = (cState_ff == C_IDLE);
  wire tfStart  = (dState_ff == D_IDLE) && dataGo && !abortPulse && !wrBlk
                  && (curCmd_ff.index == `TASKFILE_CMD) && (blkSize_ff <= `BUF_BYTES);

  chk_stall_drive: assert property (ce && stallReq |=> dat2Oe && !dat2Out)
    else $error("stall not driven while requested");
  chk_stall_release: assert property (ce && !stallReq |=> !dat2Oe)
    else $error("stall still driven after clear");
  chk_launch_accept: assert property (ce && accept && !cmd_ff.updClk
    |=> !cmd_ff.start && cState_ff == C_SEND)
    else $error("accepted command did not start or clear launch");
  chk_no_launch: assert property (ce && cIdle && !cmd_ff.start |=> cIdle)
    else $error("command left idle without launch");
  chk_wait_prev: assert property (ce && cIdle && cmd_ff.start && cmd_ff.waitPrv
    && dataBusy |=> cIdle && cmd_ff.start)
    else $error("command sent during previous data");
  chk_send_now: assert property (ce && cIdle && cmd_ff.start && !cmd_ff.waitPrv
    && !cmd_ff.updClk |=> cState_ff == C_SEND)
    else $error("command not sent at once");
  chk_data_timeout: assert property (ce && rdTimeout && !abortPulse
    |=> stat_ff.dataTo && dState_ff == D_IDLE)
    else $error("data timeout not flagged");
  chk_crc_flag: assert property (ce && respDone && curCmd_ff.checkCrc && crcBad
    |=> stat_ff.respCrc)
    else $error("bad response CRC not flagged");
  chk_crc_skip: assert property (ce && respDone && !curCmd_ff.checkCrc
    && !stat_ff.respCrc && !wrStat |=> !stat_ff.respCrc)
    else $error("CRC flagged with check disabled");
  chk_one_block: assert property (ce && tfStart && nxtBits != 10'h000
    |=> dBits_ff == {blkSize_ff[6:0], 3'b000})
    else $error("task-file transfer length wrong");
  chk_no_ccs_wait: assert property (ce && respDone |=> cIdle)
    else $error("engine waited after response");

  cov_stall: cover property (ce && ctrl_ff[`CTRL_STALL_BIT] ##1 dat2Oe);
  cov_taskfile_write: cover property (dState_ff == D_WSEND && curCmd_ff.index == `TASKFILE_CMD);
  cov_data_timeout: cover property (ce && rdTimeout);
  cov_crc_error: cover property (ce && respDone && crcFail);

endmodule

// [card_host_regs.svh]
// Register map, field positions, reset values and timing counts of the card host block
`ifndef CARD_HOST_REGS_SVH
`define CARD_HOST_REGS_SVH

// ================================================================
// Register offsets
`define OFS_CTRL        9'h000
`define OFS_TMOUT       9'h014
`define OFS_BLKSZ       9'h01C
`define OFS_BYTES       9'h020
`define OFS_CARG        9'h028
`define OFS_CMD         9'h02C
`define OFS_RESP        9'h030
`define OFS_STAT        9'h048
`define OFS_DATA        9'h100

// ================================================================
// Field positions
`define CTRL_STALL_BIT  6
`define CTRL_ABORT_BIT  8
`define ST_CMD_DONE     0
`define ST_RESP_TO      1
`define ST_RESP_CRC     2
`define ST_DATA_DONE    3
`define ST_DATA_TO      4
`define ST_CMD_BUSY     8
`define ST_DATA_BUSY    9
`define ST_RESUME       10
`define RESP_RESUME_BIT 39

// ================================================================
// Reset values
`define RST_CTRL        32'h0000_0000
`define RST_TMOUT       32'h00FF_FFFF
`define RST_BLKSZ       32'h0000_0200
`define RST_BYTES       32'h0000_0200
`define RST_CARG        32'h0000_0000
`define RST_CMD         32'h0000_0000

// ================================================================
// Timing and sizes
`define CARD_HALF_M1    8'h03
`define CMD_FRAME_BITS  8'h30
`define RESP_SHORT_LAST 8'h2F
`define RESP_LONG_LAST  8'h87
`define RESP_WAIT       8'h40
`define BUF_BYTES       32'h0000_0040
`define TASKFILE_CMD    6'h27

`endif

// [card_host_pkg.sv]
// Types shared by the card host block
package card_host_pkg;

  // Command register layout
  typedef struct packed {
    logic       start;
    logic [6:0] rsvd;
    logic       ccsExpect;
    logic       readCeata;
    logic       updClk;
    logic [4:0] cardNum;
    logic       sendInit;
    logic       stopAbort;
    logic       waitPrv;
    logic       autoStop;
    logic       xferMode;
    logic       readWrite;
    logic       dataExp;
    logic       checkCrc;
    logic       respLong;
    logic       respExp;
    logic [5:0] index;
  } cmd_t;

  // Sticky status flags
  typedef struct packed {
    logic dataTo;
    logic dataDone;
    logic respCrc;
    logic respTo;
    logic cmdDone;
  } sticky_t;

  typedef enum logic [3:0] {
    C_IDLE  = 4'h1,
    C_SEND  = 4'h2,
    C_RWAIT = 4'h4,
    C_RESP  = 4'h8
  } cmd_state_t;

  typedef enum logic [3:0] {
    D_IDLE   = 4'h1,
    D_RSTART = 4'h2,
    D_RBITS  = 4'h4,
    D_WSEND  = 4'h8
  } dat_state_t;

endpackage

// [card_buf_mem.sv]
// Small data buffer with registered read data
`timescale 1ns/10ps
module card_buf_mem (
  // Clock
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        ce,
  // Access port
  input  wire logic        wrEn,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wrData,
  output logic      [31:0] rdData
);

  logic [31:0] mem [16];
  logic [31:0] rdData_ff;

  // Storage write
  always_ff @(posedge core_clk) begin
    if (ce && wrEn) begin
      mem[addr] <= wrData;
    end
  end

  // Registered read, old data on a colliding write
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdData_ff <= 32'h0000_0000;
    end else if (ce) begin
      rdData_ff <= mem[addr];
    end
  end

  assign rdData = rdData_ff;

endmodule

// [card_model.sv]
// Behavioural card on the far side of the command and data lines
`timescale 1ns/10ps
module card_model (
  // Card bus from the host
  input  wire logic cardClk,
  input  wire logic cmdOut,
  input  wire logic cmdOe,
  input  wire logic dat0Out,
  input  wire logic dat0Oe,
  // Fault control
  input  wire logic badCrc,
  // Lines seen by the host
  output wire logic cmdIn,
  output wire logic dat0In,
  // First word of the last write block
  output logic [31:0] wrWord
);
  logic [47:0] sh;
  logic [47:0] rsp;
  logic        rspBit;
  int          n;
  // ================================================================
  // Wired lines: pull-ups win when nobody drives
  assign cmdIn  = cmdOe ? cmdOut : rspBit;
  assign dat0In = dat0Oe ? dat0Out : 1'b1; // No read data ever sent
  // Response check sum over the first 40 bits
  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int k = 39; k >= 0; k--) begin
      c = {c[5:0], 1'b0} ^ ((d[k] ^ c[6]) ? 7'h09 : 7'h00);
    end
    return c;
  endfunction
  // Take one frame, then answer two clocks later on falling edges
  initial begin
    rspBit = 1'b1;
    forever begin
      @(posedge cardClk);
      if (cmdOe && !cmdOut) begin
        for (n = 0; n < 47; n++) begin
          @(posedge cardClk);
          sh = {sh[46:0], cmdOut};
        end
        repeat (2) @(posedge cardClk);
        rsp = {2'b00, sh[45:8], 8'h01}; // Argument echoed, top bit is the data flag
        if (sh[45:40] == 6'h34 && !sh[39]) rsp[15:8] = 8'h04; // Stall support bit 2
        rsp[7:1] = crc7(rsp[47:8]) ^ {6'h00, badCrc};
        for (n = 47; n >= 0; n--) begin
          @(negedge cardClk);
          rspBit <= rsp[n];
        end
        @(negedge cardClk);
        rspBit <= 1'b1;
      end
    end
  end
  // Catch the first word of each write block, most significant bit first
  initial begin
    wrWord = 32'h0000_0000;
    forever begin
      @(posedge cardClk);
      if (dat0Oe && !dat0Out) begin
        for (int j = 0; j < 32; j++) begin
          @(posedge cardClk);
          wrWord = {wrWord[30:0], dat0Out};
        end
        wait (!dat0Oe);
      end
    end
  end
endmodule

// [card_host_readwait_taskfile_bench.sv]
// Bench for the card host read-wait and task-file block
`timescale 1ns/10ps
module card_host_readwait_taskfile_bench;
  logic        core_clk, srst, regWrEn, regRdEn, badCrc;
  logic [8:0]  regAddr;
  logic [31:0] regWrData, regRdData, v;
  wire         cardClk, cmdOut, cmdOe, cmdIn, dat0Out, dat0Oe, dat0In, dat2Out, dat2Oe;
  wire  [31:0] wrWord;
  int          error_cnt, comparisons;
  // ================================================================
  // Design and card
  card_host_readwait_taskfile card_host_readwait_taskfile_i (.core_clk, .srst, .ce(1'b1),
    .regAddr, .regWrEn, .regRdEn, .regWrData, .regRdData, .cardClk, .cmdOut, .cmdOe,
    .cmdIn, .dat0Out, .dat0Oe, .dat0In, .dat2Out, .dat2Oe);
  card_model card_model_i (.cardClk, .cmdOut, .cmdOe, .dat0Out, .dat0Oe, .badCrc,
    .cmdIn, .dat0In, .wrWord);
  // ================================================================
  // Tasks
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'b1;
    @(posedge core_clk);
    regWrEn   <= 1'b0;
  endtask
  task automatic rc(input logic [8:0] a, input logic [31:0] m, input logic [31:0] e,
                    input string nm);
    @(posedge core_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    #1 v = regRdData;
    if (nm != "") chk(nm, e, v & m);
  endtask
  // Poll a status bit under a bounded count
  task automatic poll(input int b);
    rc(9'h048, 32'h0, 32'h0, "");
    repeat (3000) if (v[b] !== 1'b1) rc(9'h048, 32'h0, 32'h0, "");
    chk("status wait", 32'h0000_0001, 32'(v[b]));
    if (v[b] !== 1'b1) end_of_test();
  endtask
  // ================================================================
  // Clock and sequence
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    {srst, regWrEn, regRdEn, regAddr, regWrData, badCrc, v} = {1'b1, 44'h0, 32'h0};
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    rc(9'h000, '1, 32'h0000_0000, "control");
    rc(9'h01C, '1, 32'h0000_0200, "block size");
    rc(9'h020, '1, 32'h0000_0200, "byte count");
    rc(9'h028, '1, 32'h0000_0000, "argument");
    rc(9'h02C, '1, 32'h0000_0000, "command");
    rc(9'h1F0, '1, 32'h0000_0000, "unmapped");
    $display("test reset values done");
    wr(9'h028, 32'h0000_1000);
    wr(9'h02C, 32'h8000_0174);
    poll(0);
    rc(9'h030, 32'h0000_0004, 32'h0000_0004, "stall support");
    wr(9'h000, 32'h0000_0040);
    rc(9'h000, '1, 32'h0000_0040, "control");
    repeat (300) @(posedge core_clk);
    #1;
    chk("stall enable", 32'h0000_0001, 32'(dat2Oe));
    chk("stall level", 32'h0000_0000, 32'(dat2Out));
    wr(9'h000, 32'h0000_0000);
    repeat (2) @(posedge core_clk);
    #1;
    chk("stall enable", 32'h0000_0000, 32'(dat2Oe));
    $display("test stall done");
    wr(9'h014, 32'h0000_0014);
    wr(9'h020, 32'h0000_0010);
    wr(9'h01C, 32'h0000_0010);
    for (int k = 0; k < 4; k++) wr(9'h100, 32'h1234_5670 + k);
    wr(9'h028, 32'h8000_0010);
    wr(9'h02C, 32'h8000_2767);
    rc(9'h02C, 32'h8000_0000, 32'h0000_0000, "launch clear");
    poll(3);
    rc(9'h048, 32'h0000_071F, 32'h0000_0409, "write status");
    rc(9'h030, '1, 32'h8000_0010, "response");
    chk("card write word", 32'h1234_5670, wrWord);
    $display("test task file write done");
    wr(9'h048, 32'h0000_001F);
    badCrc <= 1'b1;
    wr(9'h02C, 32'h8000_0174);
    poll(0);
    rc(9'h048, 32'h0000_0004, 32'h0000_0004, "crc checked");
    wr(9'h048, 32'h0000_001F);
    wr(9'h02C, 32'h8000_0074);
    poll(0);
    rc(9'h048, 32'h0000_0004, 32'h0000_0000, "crc skipped");
    badCrc <= 1'b0;
    $display("test crc done");
    wr(9'h048, 32'h0000_001F);
    wr(9'h028, 32'h0000_0010);
    wr(9'h02C, 32'h8040_2367);
    poll(9);
    wr(9'h02C, 32'h8000_2174);
    rc(9'h02C, 32'h8000_0000, 32'h8000_0000, "held launch");
    rc(9'h048, 32'h0000_0400, 32'h0000_0000, "data flag");
    poll(4);
    wr(9'h048, 32'h0000_001F);
    poll(0);
    rc(9'h02C, 32'h8000_0000, 32'h0000_0000, "launch clear");
    $display("test resumed read done");
    end_of_test();
  end
endmodule
